// >>> bench/rcc_imb_peer.sv
`timescale 1ns/10ps
module rcc_imb_peer
    import rcc_pkg::*;
(
    input  wire logic    i_clk,
    output logic         o_valid,
    output rcc_imb_evt_s o_evt
);
    initial begin
        o_valid = 1'b0;
        o_evt   = '0;
    end
    // One event, then the minimum spacing before the next
    task automatic send(input logic k, input logic [4:0] r);
        @(posedge i_clk);
        o_valid <= 1'b1;
        o_evt   <= '{kind: k, rail: r};
        @(posedge i_clk);
        o_valid <= 1'b0;
        o_evt   <= ~o_evt;
        repeat (4) @(posedge i_clk);
    endtask
endmodule

// >>> bench/rcc_rail_config_chk.sv
`timescale 1ns/10ps
module rcc_rail_config_chk
    import rcc_pkg::*;
(
    input  wire logic         i_clk,
    input  wire logic         i_resetn,
    input  wire logic         i_ce,
    input  wire logic [6:0]   i_strap_addr,
    input  wire logic         i_enable_req,
    input  wire logic         i_vout_above_pg,
    input  wire logic         o_sda_oe,
    input  wire logic         o_pg_out,
    input  wire logic         o_pg_oe,
    input  wire rcc_pwr_ctl_s o_pwr_ctl,
    input  wire logic [24:0]  o_loop_tuning,
    input  wire logic [15:0]  o_bus_id
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    sequence s_strap;
        ##[0:2] o_bus_id == {3'b000, i_strap_addr[4:0], 8'h00};
    endsequence
    sequence s_below;
        (!i_vout_above_pg && i_ce) [*6];
    endsequence
    rst_quiet_a: assert property (disable iff (1'b0) !i_resetn |=>
        !o_sda_oe && !o_pg_oe && o_pwr_ctl == '0) else $error("outputs active in reset");
    strap_load_a: assert property ($rose(i_resetn) |-> s_strap)
        else $error("bus id not loaded from strap");
    rsv_zero_a: assert property (o_bus_id[7:3] == 5'h00)
        else $error("reserved bus id bits set");
    pg_drive_a: assert property (o_pg_out |-> o_pg_oe)
        else $error("power good high but not driven");
    pg_wait_a: assert property (s_below |-> !o_pg_out)
        else $error("power good without threshold");
    out_enable_a: assert property ($rose(o_pwr_ctl.out_on) |->
        $past(i_enable_req) && $past(i_enable_req, 2)) else $error("output on without enable");
    fast_on_a: assert property (o_pwr_ctl.fast_loop_on |-> $past(o_loop_tuning[LT_EN]))
        else $error("fast loop on while tuning disabled");
    ce_hold_a: assert property (!i_ce |=> $stable(o_loop_tuning) && $stable(o_pwr_ctl))
        else $error("state moved while clock disabled");
endmodule
bind rcc_rail_config rcc_rail_config_chk u_chk (.*);

// >>> bench/rcc_rail_config_test.sv
`timescale 1ns/10ps
module rcc_rail_config_test;
    import rcc_pkg::*;
    localparam logic [6:0] ADDR = 7'h2A;
    logic clk = 0, lclk = 0, rstn = 0, ce = 1, scl = 1, mlow = 0, en = 0, vab = 0;
    logic         sda_oe, pg_out, pg_oe, ta, lvalid;
    logic [11:0]  ref_v = '0, tgt_v = '0, tt;
    logic [24:0]  tun;
    logic [31:0]  exp_q[$], obs_q[$], mv, wv[6];
    rcc_pwr_ctl_s pwr;
    rcc_imb_evt_s levt;
    int           n_errors = 0, total_checks = 0, cyc = 0, n;
    wire          sda = ~(mlow | sda_oe);
    logic [7:0]   cmds[6] = '{CMD_FEATURE, CMD_BUS_ID, CMD_PGD, CMD_TUNING, CMD_ORDER, CMD_TRACK};
    int           lens[6] = '{1, 2, 2, 4, 2, 1};
    logic [31:0]  msk[6] = '{FEATURE_MASK, BUS_ID_MASK, 32'hFFFF, TUNING_MASK,
                             ORDER_MASK, TRACK_MASK};
    logic [31:0]  rst[6] = '{FEATURE_RST, {ADDR[4:0], 8'h00}, PGD_RST, 32'h0001_1234,
                             ORDER_RST, 32'h87};
    rcc_rail_config i_dut (
        .i_clk(clk), .i_resetn(rstn), .i_ce(ce), .i_scl(scl), .i_sda(sda),
        .o_sda_out(), .o_sda_oe(sda_oe), .i_strap_addr(ADDR),
        .i_strap_tuning(25'h1_1234), .i_strap_track(8'hFF), .i_enable_req(en),
        .i_vout_above_pg(vab), .i_track_ref(ref_v), .i_vout_target(tgt_v),
        .i_imb_clk(lclk), .i_imb_valid(lvalid), .i_imb_evt(levt), .o_pg_out(pg_out),
        .o_pg_oe(pg_oe), .o_pwr_ctl(pwr), .o_track_target(tt), .o_track_active(ta),
        .o_loop_tuning(tun), .o_bus_id());
    rcc_imb_peer u_peer (.i_clk(lclk), .o_valid(lvalid), .o_evt(levt));
    initial forever #4 clk = ~clk;
    initial begin
        #1.3;
        forever #6 lclk = ~lclk;
    end
    always @(negedge clk) while (obs_q.size() > 0) begin
        mv = obs_q.pop_front();
        total_checks++;
        if (exp_q.size() == 0 || mv !== exp_q[0]) begin
            n_errors++;
            $display("[ERR] %0t value %h mismatch", $time, mv);
        end
        if (exp_q.size() > 0) void'(exp_q.pop_front());
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            n_errors++;
            end_sim();
        end
    end
    task automatic end_sim();
        if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic tick(int c);
        repeat (c) @(negedge clk);
    endtask
    task automatic chk(logic [31:0] e, logic [31:0] a);
        exp_q.push_back(e);
        obs_q.push_back(a);
    endtask
    task automatic bitx(logic b, output logic s);
        mlow = ~b;
        tick(6);
        scl = 1;
        tick(3);
        s = sda;
        tick(3);
        scl = 0;
    endtask
    task automatic sta();
        mlow = 0;
        tick(6);
        scl = 1;
        tick(6);
        mlow = 1;
        tick(6);
        scl = 0;
    endtask
    task automatic stp();
        mlow = 1;
        tick(6);
        scl = 1;
        tick(6);
        mlow = 0;
        tick(6);
    endtask
    task automatic xfer(logic [7:0] d, logic ack, output logic [7:0] q);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], s);
            q[i] = s;
        end
        bitx(ack, s);
    endtask
    task automatic wr(logic [7:0] c, logic [31:0] v, int k);
        logic [7:0] q;
        sta();
        xfer({ADDR, 1'b0}, 1'b1, q);
        xfer(c, 1'b1, q);
        for (int i = 0; i < k; i++) xfer(v[8*i+:8], 1'b1, q);
        stp();
        tick(4);
    endtask
    task automatic rd(logic [7:0] c, int k);
        logic [7:0]  q;
        logic [31:0] v;
        v = '0;
        sta();
        xfer({ADDR, 1'b0}, 1'b1, q);
        xfer(c, 1'b1, q);
        sta();
        xfer({ADDR, 1'b1}, 1'b1, q);
        for (int i = 0; i < k; i++) begin
            xfer(8'hFF, i == k - 1, q);
            v[8*i+:8] = q;
        end
        stp();
        obs_q.push_back(v);
    endtask
    task automatic track(logic [7:0] v, logic [12:0] e);
        wr(CMD_TRACK, v, 1);
        chk(e, {ta, ta ? tt : 12'h000});
    endtask
    initial begin
        void'($urandom(32'hBCED_00E7));
        tick(3);
        rstn = 1;
        tick(6);
        for (int k = 0; k < 6; k++) begin
            exp_q.push_back(rst[k]);
            rd(cmds[k], lens[k]);
        end
        exp_q.push_back(32'h0000_FF84);
        rd(CMD_FEATURE, 2);
        for (int k = 0; k < 6; k++) begin
            wv[k] = $urandom() | 32'h0100_0000;
            wr(cmds[k], wv[k], lens[k]);
            exp_q.push_back(wv[k] & msk[k]);
            rd(cmds[k], lens[k]);
        end
        chk(wv[3] & TUNING_MASK, tun);
        for (int k = 0; k < 4; k++) begin
            wr(CMD_FEATURE, {k[1:0], k[0], 2'b00}, 1);
            chk({k[0], k[1:0]}, {pwr.min_duty_en, pwr.min_duty_code});
        end
        wr(CMD_ORDER, 0, 2);
        wr(CMD_FEATURE, 32'h06, 1);
        wr(CMD_PGD, 32'hD001, 2);
        en = 1;
        ce = 0;
        tick(3);
        ce = 1;
        tick(8);
        chk(2'b10, {pwr.out_on, pwr.fast_loop_on});
        vab = 1;
        n = 0;
        while (pg_out !== 1'b1 && n < 3000) begin
            tick(1);
            n++;
        end
        chk(1, n >= 2000 && n <= 2008);
        tick(2);
        chk(3'b111, {pwr.out_on, pwr.fast_loop_on, pg_oe});
        wr(CMD_PGD, 32'h0001, 2);
        wr(CMD_FEATURE, 32'h84, 1);
        chk(2'b00, {pg_out, pg_oe});
        en = 0;
        tick(8);
        wr(CMD_ORDER, 32'h8589, 2);
        en = 1;
        tick(20);
        u_peer.send(EVT_POWER_GOOD, 5'd4);
        u_peer.send(EVT_POWER_DOWN, 5'd5);
        chk(0, pwr.out_on);
        u_peer.send(EVT_POWER_GOOD, 5'd5);
        tick(4);
        chk(1, pwr.out_on);
        u_peer.send(EVT_POWER_DOWN, 5'd9);
        tick(4);
        chk(0, pwr.out_on);
        ref_v = 12'd800;
        tgt_v = 12'd500;
        track(8'h87, {1'b1, 12'd400});
        track(8'h83, {1'b1, 12'd800});
        track(8'h81, {1'b1, 12'd500});
        track(8'h01, 13'h0000);
        tick(4);
        end_sim();
    end
endmodule

// >>> common/rcc_pkg.sv
package rcc_pkg;

    // Command codes of the configuration registers
    localparam logic [7:0]  CMD_FEATURE   = 8'hD1;
    localparam logic [7:0]  CMD_BUS_ID    = 8'hD3;
    localparam logic [7:0]  CMD_PGD       = 8'hD4;
    localparam logic [7:0]  CMD_TUNING    = 8'hDF;
    localparam logic [7:0]  CMD_ORDER     = 8'hE0;
    localparam logic [7:0]  CMD_TRACK     = 8'hE1;

    // Data bytes per command
    localparam logic [2:0]  LEN_BYTE      = 3'h1;
    localparam logic [2:0]  LEN_WORD      = 3'h2;
    localparam logic [2:0]  LEN_DWORD     = 3'h4;

    // Values after reset, and the byte read past the end of a register
    localparam logic [7:0]  FEATURE_RST   = 8'h84;
    localparam logic [15:0] BUS_ID_RST    = 16'h0000;
    localparam logic [15:0] PGD_RST       = 16'hC300;
    localparam logic [15:0] ORDER_RST     = 16'h0000;
    localparam logic [7:0]  READ_FILL     = 8'hFF;

    // Writable bits; all others read as zero
    localparam logic [7:0]  FEATURE_MASK  = 8'h9E;
    localparam logic [15:0] BUS_ID_MASK   = 16'hFF07;
    localparam logic [31:0] TUNING_MASK   = 32'h01FF_FFFF;
    localparam logic [15:0] ORDER_MASK    = 16'h9F9F;
    localparam logic [7:0]  TRACK_MASK    = 8'h87;

    // Field positions
    localparam int FO_FAST_START = 7;
    localparam int FO_MIN_LO     = 3;
    localparam int FO_MIN_EN     = 2;
    localparam int FO_PG_PUSH    = 1;
    localparam int BI_PHASE_LO   = 13;
    localparam int BI_RAIL_LO    = 8;
    localparam int BI_COUNT_LO   = 0;
    localparam int LT_EN         = 24;
    localparam int RO_PRE_EN     = 15;
    localparam int RO_PRE_LO     = 8;
    localparam int RO_SEQ_EN     = 7;
    localparam int RO_SEQ_LO     = 0;
    localparam int TR_EN         = 7;
    localparam int TR_HALF       = 2;
    localparam int TR_LIM_REF    = 1;
    localparam int TR_ALWAYS     = 0;

    // Power-good delay timing
    localparam int CLK_PERIOD_PS = 8000;
    localparam int PG_STEP_PS    = 125000;
    localparam int MS_PS         = 1000000000;
    localparam int PG_STEP_CYC   = (PG_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [12:0] STEPS_PER_MS = 13'(MS_PS / PG_STEP_PS);

    typedef enum logic [5:0] {
        ST_IDLE  = 6'b00_0001,
        ST_ADDR  = 6'b00_0010,
        ST_WBYTE = 6'b00_0100,
        ST_ACK   = 6'b00_1000,
        ST_RBYTE = 6'b01_0000,
        ST_RACK  = 6'b10_0000
    } rcc_bus_st_e;

    // Event kinds on the inter-module bus
    localparam logic EVT_POWER_DOWN = 1'b0;
    localparam logic EVT_POWER_GOOD = 1'b1;

    typedef struct packed {
        logic       kind;
        logic [4:0] rail;
    } rcc_imb_evt_s;

    typedef struct packed {
        logic       out_on;
        logic       fast_loop_on;
        logic       min_duty_en;
        logic [1:0] min_duty_code;
    } rcc_pwr_ctl_s;

endpackage

// >>> rtl/rcc_rail_config.sv
`timescale 1ns/10ps
module rcc_rail_config
    import rcc_pkg::*;
#(
    parameter int TRK_W = 12
) (
    input  wire logic             i_clk,
    input  wire logic             i_resetn,
    input  wire logic             i_ce,
    input  wire logic             i_scl,
    input  wire logic             i_sda,
    output logic                  o_sda_out,
    output logic                  o_sda_oe,
    input  wire logic [6:0]       i_strap_addr,
    input  wire logic [24:0]      i_strap_tuning,
    input  wire logic [7:0]       i_strap_track,
    input  wire logic             i_enable_req,
    input  wire logic             i_vout_above_pg,
    input  wire logic [TRK_W-1:0] i_track_ref,
    input  wire logic [TRK_W-1:0] i_vout_target,
    input  wire logic             i_imb_clk,
    input  wire logic             i_imb_valid,
    input  wire rcc_imb_evt_s     i_imb_evt,
    output logic                  o_pg_out,
    output logic                  o_pg_oe,
    output rcc_pwr_ctl_s          o_pwr_ctl,
    output logic [TRK_W-1:0]      o_track_target,
    output logic                  o_track_active,
    output logic [24:0]           o_loop_tuning,
    output logic [15:0]           o_bus_id
);

    localparam int AW = 4 + 7 + 25 + 8;

    function automatic logic [2:0] cmd_len(input logic [7:0] c);
        unique case (c)
            CMD_FEATURE, CMD_TRACK:           cmd_len = LEN_BYTE;
            CMD_BUS_ID, CMD_PGD, CMD_ORDER:   cmd_len = LEN_WORD;
            CMD_TUNING:                       cmd_len = LEN_DWORD;
            default:                          cmd_len = 3'h0;
        endcase
    endfunction

    // Linear-11 milliseconds to 125 ns steps; negative mantissa counts as zero
    function automatic logic [39:0] l11_steps(input logic [15:0] v);
        logic [39:0] prod;
        logic [4:0]  neg;
        prod = v[10] ? 40'h0 : 40'(24'(v[9:0]) * 24'(STEPS_PER_MS));
        neg  = ~v[15:11] + 5'h01;
        if (v[15]) begin
            l11_steps = prod >> neg;
        end else begin
            l11_steps = prod << v[15:11];
        end
    endfunction

    // Pin synchronisers
    logic [AW-1:0] sync1_q;
    logic [AW-1:0] sync2_q;
    logic          scl3_q;
    logic          sda3_q;
    logic          scl_s;
    logic          sda_s;
    logic          en_s;
    logic          above_s;
    logic [6:0]    addr_s;
    logic [24:0]   tune_s;
    logic [7:0]    track_s;

    // No reset here: straps settle through the syncs while reset is held
    always_ff @(posedge i_clk) begin
        if (i_ce) begin
            sync1_q <= {i_scl, i_sda, i_enable_req, i_vout_above_pg,
                        i_strap_addr, i_strap_tuning, i_strap_track};
            sync2_q <= sync1_q;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            scl3_q <= 1'b1;
            sda3_q <= 1'b1;
        end else if (i_ce) begin
            scl3_q <= scl_s;
            sda3_q <= sda_s;
        end
    end

    assign {scl_s, sda_s, en_s, above_s, addr_s, tune_s, track_s} = sync2_q;

    wire scl_rise = scl_s & ~scl3_q;
    wire scl_fall = ~scl_s & scl3_q;
    wire bus_start = scl_s & scl3_q & sda3_q & ~sda_s;
    wire bus_stop  = scl_s & scl3_q & ~sda3_q & sda_s;

    // Inter-module bus capture on its own clock
    logic         lrst1_q;
    logic         lrst2_q;
    logic         ltog_q;
    rcc_imb_evt_s lhold_q;

    always_ff @(posedge i_imb_clk) begin
        lrst1_q <= i_resetn;
        lrst2_q <= lrst1_q;
    end

    always_ff @(posedge i_imb_clk) begin
        if (!lrst2_q) begin
            ltog_q  <= 1'b0;
            lhold_q <= '0;
        end else if (i_imb_valid) begin
            lhold_q <= i_imb_evt;
            ltog_q  <= ~ltog_q;
        end
    end

    logic tog1_q;
    logic tog2_q;
    logic tog3_q;

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            tog1_q <= 1'b0;
            tog2_q <= 1'b0;
            tog3_q <= 1'b0;
        end else if (i_ce) begin
            tog1_q <= ltog_q;
            tog2_q <= tog1_q;
            tog3_q <= tog2_q;
        end
    end

    wire evt_stb = tog2_q ^ tog3_q;

    // Registers
    logic [7:0]  feature_q;
    logic [15:0] bus_id_q;
    logic [15:0] pgd_q;
    logic [31:0] tuning_q;
    logic [15:0] order_q;
    logic [7:0]  track_q;
    logic [6:0]  addr_q;
    logic        load_pend_q;
    logic        wr_stb_q;
    logic [7:0]  cmd_q;
    logic [31:0] wbuf_q;

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            feature_q   <= FEATURE_RST;
            bus_id_q    <= BUS_ID_RST;
            pgd_q       <= PGD_RST;
            tuning_q    <= '0;
            order_q     <= ORDER_RST;
            track_q     <= '0;
            addr_q      <= '0;
            load_pend_q <= 1'b1;
        end else if (i_ce) begin
            if (load_pend_q) begin
                load_pend_q <= 1'b0;
                addr_q      <= addr_s;
                bus_id_q[BI_RAIL_LO +: 5] <= addr_s[4:0];
                tuning_q    <= {7'h00, tune_s};
                track_q     <= track_s & TRACK_MASK;
            end else if (wr_stb_q) begin
                unique case (cmd_q)
                    CMD_FEATURE: feature_q <= wbuf_q[7:0] & FEATURE_MASK;
                    CMD_BUS_ID:  bus_id_q  <= wbuf_q[15:0] & BUS_ID_MASK;
                    CMD_PGD:     pgd_q     <= wbuf_q[15:0];
                    CMD_TUNING:  tuning_q  <= wbuf_q & TUNING_MASK;
                    CMD_ORDER:   order_q   <= wbuf_q[15:0] & ORDER_MASK;
                    CMD_TRACK:   track_q   <= wbuf_q[7:0] & TRACK_MASK;
                    default:     ;
                endcase
            end
        end
    end

    logic [31:0] rd_word;
    always_comb begin
        unique case (cmd_q)
            CMD_FEATURE: rd_word = {24'h0, feature_q};
            CMD_BUS_ID:  rd_word = {16'h0, bus_id_q};
            CMD_PGD:     rd_word = {16'h0, pgd_q};
            CMD_TUNING:  rd_word = tuning_q;
            CMD_ORDER:   rd_word = {16'h0, order_q};
            CMD_TRACK:   rd_word = {24'h0, track_q};
            default:     rd_word = '0;
        endcase
    end

    // Management bus slave, data bytes low byte first
    rcc_bus_st_e st_q;
    logic [2:0]  bitcnt_q;
    logic [7:0]  shift_q;
    logic [2:0]  nbytes_q;
    logic        rw_q;
    logic        got_cmd_q;
    logic        done_q;
    logic        sda_oe_q;

    wire [2:0] cur_len = cmd_len(cmd_q);
    wire [7:0] rd_byte = (nbytes_q < cur_len) ? rd_word[{nbytes_q[1:0], 3'b000} +: 8]
                                              : READ_FILL;

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            st_q      <= ST_IDLE;
            bitcnt_q  <= '0;
            shift_q   <= '0;
            nbytes_q  <= '0;
            rw_q      <= 1'b0;
            got_cmd_q <= 1'b0;
            done_q    <= 1'b0;
            sda_oe_q  <= 1'b0;
            cmd_q     <= '0;
            wbuf_q    <= '0;
            wr_stb_q  <= 1'b0;
        end else if (i_ce) begin
            wr_stb_q <= 1'b0;
            if (bus_start) begin
                st_q     <= ST_ADDR;
                bitcnt_q <= '0;
                done_q   <= 1'b0;
                sda_oe_q <= 1'b0;
            end else if (bus_stop) begin
                wr_stb_q  <= ~rw_q & got_cmd_q & (nbytes_q == cur_len);
                st_q      <= ST_IDLE;
                sda_oe_q  <= 1'b0;
                got_cmd_q <= 1'b0;
                nbytes_q  <= '0;
            end else begin
                unique case (st_q)
                    ST_ADDR, ST_WBYTE: begin
                        if (scl_rise) begin
                            shift_q  <= {shift_q[6:0], sda_s};
                            bitcnt_q <= bitcnt_q + 3'h1;
                            done_q   <= (bitcnt_q == 3'h7);
                        end else if (scl_fall && done_q) begin
                            done_q <= 1'b0;
                            st_q   <= ST_IDLE;
                            if (st_q == ST_ADDR) begin
                                if (shift_q[7:1] == addr_q && (!shift_q[0] || got_cmd_q)) begin
                                    rw_q     <= shift_q[0];
                                    nbytes_q <= '0;
                                    sda_oe_q <= 1'b1;
                                    st_q     <= ST_ACK;
                                end
                            end else if (!got_cmd_q) begin
                                if (cmd_len(shift_q) != 3'h0) begin
                                    cmd_q     <= shift_q;
                                    got_cmd_q <= 1'b1;
                                    nbytes_q  <= '0;
                                    sda_oe_q  <= 1'b1;
                                    st_q      <= ST_ACK;
                                end
                            end else if (nbytes_q < cur_len) begin
                                wbuf_q[{nbytes_q[1:0], 3'b000} +: 8] <= shift_q;
                                nbytes_q <= nbytes_q + 3'h1;
                                sda_oe_q <= 1'b1;
                                st_q     <= ST_ACK;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            bitcnt_q <= '0;
                            if (rw_q) begin
                                sda_oe_q <= ~rd_byte[7];
                                shift_q  <= {rd_byte[6:0], 1'b0};
                                st_q     <= ST_RBYTE;
                            end else begin
                                sda_oe_q <= 1'b0;
                                st_q     <= ST_WBYTE;
                            end
                        end
                    end
                    ST_RBYTE: begin
                        if (scl_rise) begin
                            bitcnt_q <= bitcnt_q + 3'h1;
                            done_q   <= (bitcnt_q == 3'h7);
                        end else if (scl_fall) begin
                            if (done_q) begin
                                done_q   <= 1'b0;
                                sda_oe_q <= 1'b0;
                                st_q     <= ST_RACK;
                            end else begin
                                sda_oe_q <= ~shift_q[7];
                                shift_q  <= {shift_q[6:0], 1'b0};
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            if (sda_s) begin
                                st_q <= ST_IDLE;
                            end else begin
                                nbytes_q <= nbytes_q + 3'h1;
                                done_q   <= 1'b1;
                            end
                        end else if (scl_fall && done_q) begin
                            done_q   <= 1'b0;
                            bitcnt_q <= '0;
                            sda_oe_q <= ~rd_byte[7];
                            shift_q  <= {rd_byte[6:0], 1'b0};
                            st_q     <= ST_RBYTE;
                        end
                    end
                    default: st_q <= ST_IDLE;
                endcase
            end
        end
    end

    // Power-good delay
    logic [39:0] steps_q;
    logic [39:0] steps_done_q;
    logic [4:0]  pre_q;
    logic        pg_q;

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            steps_q      <= '0;
            steps_done_q <= '0;
            pre_q        <= '0;
            pg_q         <= 1'b0;
        end else if (i_ce) begin
            steps_q <= l11_steps(pgd_q);
            if (!above_s) begin
                steps_done_q <= '0;
                pre_q        <= '0;
                pg_q         <= 1'b0;
            end else if (!pg_q) begin
                if (steps_done_q >= steps_q) begin
                    pg_q <= 1'b1;
                end else if (pre_q == 5'(PG_STEP_CYC - 1)) begin
                    pre_q        <= '0;
                    steps_done_q <= steps_done_q + 40'h1;
                end else begin
                    pre_q <= pre_q + 5'h01;
                end
            end
        end
    end

    // Sequencing on the inter-module bus
    logic pre_seen_q;
    logic seq_down_q;
    logic out_on_q;

    wire pre_en  = order_q[RO_PRE_EN];
    wire seq_en  = order_q[RO_SEQ_EN];
    wire pre_hit = evt_stb && lhold_q.kind == EVT_POWER_GOOD
                   && lhold_q.rail == order_q[RO_PRE_LO +: 5];
    wire seq_hit = evt_stb && lhold_q.kind == EVT_POWER_DOWN
                   && lhold_q.rail == order_q[RO_SEQ_LO +: 5];
    wire turn_on  = ~out_on_q & en_s & ~(seq_en & seq_down_q)
                    & (~pre_en | pre_seen_q);
    wire turn_off = out_on_q & (seq_en ? seq_down_q : ~en_s);

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            pre_seen_q <= 1'b0;
            seq_down_q <= 1'b0;
            out_on_q   <= 1'b0;
        end else if (i_ce) begin
            if (pre_hit) begin
                pre_seen_q <= 1'b1;
            end else if (turn_off) begin
                pre_seen_q <= 1'b0;
            end
            if (seq_hit) begin
                seq_down_q <= 1'b1;
            end else if (!en_s) begin
                seq_down_q <= 1'b0;
            end
            if (turn_on) begin
                out_on_q <= 1'b1;
            end else if (turn_off) begin
                out_on_q <= 1'b0;
            end
        end
    end

    // Power stage controls and power-good pin
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_pwr_ctl <= '0;
            o_pg_out  <= 1'b0;
            o_pg_oe   <= 1'b0;
        end else if (i_ce) begin
            o_pwr_ctl.out_on        <= out_on_q;
            o_pwr_ctl.fast_loop_on  <= tuning_q[LT_EN]
                & (~(out_on_q & ~pg_q) | feature_q[FO_FAST_START]);
            o_pwr_ctl.min_duty_en   <= feature_q[FO_MIN_EN];
            o_pwr_ctl.min_duty_code <= feature_q[FO_MIN_LO +: 2];
            if (feature_q[FO_PG_PUSH]) begin
                o_pg_out <= pg_q;
                o_pg_oe  <= 1'b1;
            end else begin
                o_pg_out <= 1'b0;
                o_pg_oe  <= ~pg_q;
            end
        end
    end

    // Tracking target
    logic [TRK_W-1:0] scaled;
    logic [TRK_W-1:0] limit;
    logic [TRK_W-1:0] cand;

    always_comb begin
        scaled = track_q[TR_HALF] ? (i_track_ref >> 1) : i_track_ref;
        limit  = track_q[TR_LIM_REF] ? i_track_ref : i_vout_target;
        cand   = (scaled < limit) ? scaled : limit;
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_track_target <= '0;
            o_track_active <= 1'b0;
        end else if (i_ce) begin
            o_track_active <= track_q[TR_EN];
            if (!track_q[TR_EN]) begin
                o_track_target <= i_vout_target;
            end else if (track_q[TR_ALWAYS] || pg_q || cand >= o_track_target) begin
                o_track_target <= cand;
            end
        end
    end

    assign o_sda_out     = 1'b0;
    assign o_sda_oe      = sda_oe_q;
    assign o_loop_tuning = tuning_q[24:0];
    assign o_bus_id      = bus_id_q;

endmodule
